// >>> rtl/phy_vendor_regs_pkg.sv
package phy_vendor_regs_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register offsets on the management port
  localparam logic [4:0] OFF_SPECIAL_CTRL = 5'h10;
  localparam logic [4:0] OFF_IRQ_CTRL     = 5'h11;

  // special control register fields
  localparam int CTRL_DEBUG      = 15;
  localparam int CTRL_MDIX_OFF   = 11;
  localparam int CTRL_HEARTBEAT  = 10;
  localparam int CTRL_JABBER     = 9;
  localparam int CTRL_FAR_FAULT  = 8;
  localparam int CTRL_AN_PS_DIS  = 7;
  localparam int CTRL_DSP_BYPASS = 5;
  localparam int CTRL_REPEATER   = 2;
  localparam int CTRL_APS        = 1;
  localparam int CTRL_ANALOG_OFF = 0;

  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_WMASK  = 16'h8FA7;
  // bits kept across a software reset
  localparam logic [15:0] CTRL_STICKY = 16'h87A7;

  // interrupt control/status register fields
  localparam int IRQ_PIN_EN     = 15;
  localparam int IRQ_MASK_ALL   = 11;
  localparam int IRQ_MASK_SPEED = 10;
  localparam int IRQ_MASK_DUPLX = 9;
  localparam int IRQ_MASK_LINK  = 8;
  localparam int IRQ_ARB_EN     = 7;
  localparam int IRQ_FLAG_ARB   = 6;
  localparam int IRQ_FLAG_LINK  = 2;
  localparam int IRQ_FLAG_SPEED = 1;
  localparam int IRQ_FLAG_DUPLX = 0;

  localparam logic [15:0] IRQ_RESET = 16'h0E00;
  localparam logic [15:0] IRQ_WMASK = 16'h8F80;

  // event vector order used between the two modules
  localparam int EVT_DUPLX = 0;
  localparam int EVT_SPEED = 1;
  localparam int EVT_LINK  = 2;
  localparam int EVT_ARB   = 3;
  localparam int EVT_N     = 4;

endpackage

// >>> rtl/irq_event_flags.sv
`timescale 1ns/1ps

module irq_event_flags (
  // clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   rst_n,
  // event strobes and read-clear
  input  wire logic [phy_vendor_regs_pkg::EVT_N-1:0]  events,
  input  wire logic                                   clear,
  // gating from the interrupt register
  input  wire logic                                   mask_all,
  input  wire logic                                   mask_speed,
  input  wire logic                                   mask_duplex,
  input  wire logic                                   mask_link,
  input  wire logic                                   arb_en,
  // flags and pending level
  output logic      [phy_vendor_regs_pkg::EVT_N-1:0]  flags,
  output logic                                        pending
);

  typedef struct packed {
    logic [phy_vendor_regs_pkg::EVT_N-1:0] flags;
  } flags_s;

  flags_s state;
  flags_s next_state;
  logic [phy_vendor_regs_pkg::EVT_N-1:0] enabled;

  always_comb begin
    next_state = state;
    // an event in the clearing cycle survives the read
    next_state.flags = (state.flags & ~{phy_vendor_regs_pkg::EVT_N{clear}}) | events;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    enabled = '0;
    enabled[phy_vendor_regs_pkg::EVT_SPEED] = ~mask_speed;
    enabled[phy_vendor_regs_pkg::EVT_DUPLX] = ~mask_duplex;
    enabled[phy_vendor_regs_pkg::EVT_LINK]  = ~mask_link;
    enabled[phy_vendor_regs_pkg::EVT_ARB]   = arb_en;
  end

  assign flags   = state.flags;
  assign pending = ~mask_all & (|(state.flags & enabled));

  read_clear_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clear && events == '0 |=> flags == '0)
    else $error("flags not cleared by read");

  event_sets_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    events[phy_vendor_regs_pkg::EVT_ARB] |=> flags[phy_vendor_regs_pkg::EVT_ARB])
    else $error("arbiter event lost");

  arb_gate_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !arb_en && flags == 4'h8 |-> !pending)
    else $error("disabled arbiter event raised interrupt");

  link_mask_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mask_link && flags == 4'h4 |-> !pending)
    else $error("masked link event raised interrupt");

endmodule // irq_event_flags

// >>> rtl/phy_vendor_ctrl_irq_regs.sv
`timescale 1ns/1ps

// Behaviour
// - bit 15 selects normal or debug mode
// - software reset keeps programmed sticky control bits
// - bit 11 high stops automatic crossover switching
// - negotiation strapped off sets crossover-disable bit
// - bit 10 enables heartbeat in 10BASE-T
// - bit 9 enables jabber in 10BASE-T
// - bit 8 enables far-end fault in 100BASE-TX
// - bit 7 disables power saving during negotiation
// - bit 5 bypasses receive DSP reset
// - bit 2 selects repeater mode
// - bit 1 enables automatic power saving
// - bit 0 powers down analog section
// - interrupt pin driven only when enable bit set
// - global mask blocks every interrupt
// - speed, duplex, link masks suppress their interrupts; their flags still set
// - arbiter events interrupt only when enabled
// - arbiter change flag clears on read
// - link, speed, duplex flags clear on read
module phy_vendor_ctrl_irq_regs (
  // clock and reset
  input  wire logic                                    mclk,
  input  wire logic                                    resetn,
  // register port from the management engine
  input  wire logic [phy_vendor_regs_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  input  wire logic [phy_vendor_regs_pkg::DATA_W-1:0]  reg_wdata,
  output logic      [phy_vendor_regs_pkg::DATA_W-1:0]  reg_rdata,
  // software reset and strap
  input  wire logic                                    soft_reset,
  input  wire logic                                    an_strap_off,
  // status change strobes
  input  wire logic                                    speed_change,
  input  wire logic                                    duplex_change,
  input  wire logic                                    link_change,
  input  wire logic                                    arbiter_change,
  // control levels to the rest of the transceiver
  output logic                                         debug_mode,
  output logic                                         mdix_auto_disable,
  output logic                                         heartbeat_en,
  output logic                                         jabber_en,
  output logic                                         far_end_fault_en,
  output logic                                         an_power_save_disable,
  output logic                                         dsp_reset_bypass,
  output logic                                         repeater_mode,
  output logic                                         auto_power_save,
  output logic                                         analog_power_down,
  // interrupt pin, tri-state
  output logic                                         irq_output,
  output logic                                         irq_output_oe
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] irq_cfg;
    logic [15:0] rdata;
    logic        strap_done;
    logic        strap_an_off;
  } regs_s;

  regs_s state;
  regs_s next_state;

  logic        rst_meta;
  logic        rst_sync;
  logic [phy_vendor_regs_pkg::EVT_N-1:0] events;
  logic [phy_vendor_regs_pkg::EVT_N-1:0] flags;
  logic        pending;
  logic        wr_ctrl;
  logic        wr_irq;
  logic        rd_ctrl;
  logic        rd_irq;

  // the flags sit in two separate groups of the status word
  function automatic logic [15:0] place_flags(input logic [phy_vendor_regs_pkg::EVT_N-1:0] f);
    logic [15:0] w;
    w = '0;
    w[phy_vendor_regs_pkg::IRQ_FLAG_ARB]   = f[phy_vendor_regs_pkg::EVT_ARB];
    w[phy_vendor_regs_pkg::IRQ_FLAG_LINK]  = f[phy_vendor_regs_pkg::EVT_LINK];
    w[phy_vendor_regs_pkg::IRQ_FLAG_SPEED] = f[phy_vendor_regs_pkg::EVT_SPEED];
    w[phy_vendor_regs_pkg::IRQ_FLAG_DUPLX] = f[phy_vendor_regs_pkg::EVT_DUPLX];
    return w;
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign wr_ctrl = reg_wr && reg_addr == phy_vendor_regs_pkg::OFF_SPECIAL_CTRL;
  assign wr_irq  = reg_wr && reg_addr == phy_vendor_regs_pkg::OFF_IRQ_CTRL;
  assign rd_ctrl = reg_rd && reg_addr == phy_vendor_regs_pkg::OFF_SPECIAL_CTRL;
  assign rd_irq  = reg_rd && reg_addr == phy_vendor_regs_pkg::OFF_IRQ_CTRL;

  always_comb begin
    events = '0;
    events[phy_vendor_regs_pkg::EVT_SPEED] = speed_change;
    events[phy_vendor_regs_pkg::EVT_DUPLX] = duplex_change;
    events[phy_vendor_regs_pkg::EVT_LINK]  = link_change;
    events[phy_vendor_regs_pkg::EVT_ARB]   = arbiter_change;
  end

  always_comb begin
    next_state = state;
    // strap is caught on the first edge after reset release
    if (!state.strap_done) begin
      next_state.strap_done   = 1'b1;
      next_state.strap_an_off = an_strap_off;
      if (an_strap_off) begin
        next_state.ctrl[phy_vendor_regs_pkg::CTRL_MDIX_OFF] = 1'b1;
      end
    end
    // only the non-sticky crossover bit returns to its strap default
    if (soft_reset) begin
      next_state.ctrl = (state.ctrl & phy_vendor_regs_pkg::CTRL_STICKY)
                      | (phy_vendor_regs_pkg::CTRL_RESET & ~phy_vendor_regs_pkg::CTRL_STICKY);
      // strap value of this cycle, so a reset racing the strap capture still sees it
      next_state.ctrl[phy_vendor_regs_pkg::CTRL_MDIX_OFF] = next_state.strap_an_off;
    end
    // a write in the same cycle as a software reset wins
    if (wr_ctrl) begin
      next_state.ctrl = reg_wdata & phy_vendor_regs_pkg::CTRL_WMASK;
    end
    if (wr_irq) begin
      next_state.irq_cfg = reg_wdata & phy_vendor_regs_pkg::IRQ_WMASK;
    end
    if (rd_ctrl) begin
      next_state.rdata = state.ctrl;
    end else if (rd_irq) begin
      next_state.rdata = state.irq_cfg | place_flags(flags);
    end else if (reg_rd) begin
      next_state.rdata = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      state.ctrl         <= phy_vendor_regs_pkg::CTRL_RESET;
      state.irq_cfg      <= phy_vendor_regs_pkg::IRQ_RESET;
      state.rdata        <= '0;
      state.strap_done   <= 1'b0;
      state.strap_an_off <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  irq_event_flags irq_event_flags_i (
    .mclk        (mclk),
    .rst_n       (rst_sync),
    .events      (events),
    .clear       (rd_irq),
    .mask_all    (state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_ALL]),
    .mask_speed  (state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_SPEED]),
    .mask_duplex (state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_DUPLX]),
    .mask_link   (state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_LINK]),
    .arb_en      (state.irq_cfg[phy_vendor_regs_pkg::IRQ_ARB_EN]),
    .flags       (flags),
    .pending     (pending)
  );

  assign reg_rdata             = state.rdata;
  assign debug_mode            = state.ctrl[phy_vendor_regs_pkg::CTRL_DEBUG];
  assign mdix_auto_disable     = state.ctrl[phy_vendor_regs_pkg::CTRL_MDIX_OFF];
  assign heartbeat_en          = state.ctrl[phy_vendor_regs_pkg::CTRL_HEARTBEAT];
  assign jabber_en             = state.ctrl[phy_vendor_regs_pkg::CTRL_JABBER];
  assign far_end_fault_en      = state.ctrl[phy_vendor_regs_pkg::CTRL_FAR_FAULT];
  assign an_power_save_disable = state.ctrl[phy_vendor_regs_pkg::CTRL_AN_PS_DIS];
  assign dsp_reset_bypass      = state.ctrl[phy_vendor_regs_pkg::CTRL_DSP_BYPASS];
  assign repeater_mode         = state.ctrl[phy_vendor_regs_pkg::CTRL_REPEATER];
  assign auto_power_save       = state.ctrl[phy_vendor_regs_pkg::CTRL_APS];
  assign analog_power_down     = state.ctrl[phy_vendor_regs_pkg::CTRL_ANALOG_OFF];
  // active high while an unmasked flag is pending; the pin floats when disabled
  assign irq_output            = pending;
  assign irq_output_oe         = state.irq_cfg[phy_vendor_regs_pkg::IRQ_PIN_EN];

  soft_sticky_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    soft_reset && !reg_wr && state.strap_done |=>
      (state.ctrl & phy_vendor_regs_pkg::CTRL_STICKY)
      == ($past(state.ctrl) & phy_vendor_regs_pkg::CTRL_STICKY))
    else $error("software reset altered a sticky bit");

  strap_mdix_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    !state.strap_done && an_strap_off && !wr_ctrl |=> mdix_auto_disable)
    else $error("strap did not disable crossover");

  ctrl_write_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=> mdix_auto_disable == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_MDIX_OFF]) &&
      analog_power_down == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_ANALOG_OFF]) &&
      debug_mode == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_DEBUG]))
    else $error("control write not taken");

  pin_hiz_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_irq |=> irq_output_oe == $past(reg_wdata[15]))
    else $error("pin enable not following register");

  all_mask_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_ALL] |-> !irq_output)
    else $error("interrupt while globally masked");

  irq_cause_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_irq && reg_wdata == 16'h8000 ##1 !wr_irq ##1 link_change && !wr_irq
      ##1 !wr_irq && !rd_irq |-> irq_output ##1 irq_output)
    else $error("unmasked link event gave no interrupt");

  heartbeat_wr_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=> heartbeat_en == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_HEARTBEAT]))
    else $error("heartbeat enable not taken");

  jabber_wr_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=> jabber_en == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_JABBER]))
    else $error("jabber enable not taken");

  far_fault_wr_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=> far_end_fault_en == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_FAR_FAULT]))
    else $error("far-end fault enable not taken");

  ps_disable_wr_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=>
      an_power_save_disable == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_AN_PS_DIS]))
    else $error("power saving disable not taken");

  dsp_bypass_wr_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=> dsp_reset_bypass == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_DSP_BYPASS]))
    else $error("dsp reset bypass not taken");

  repeater_wr_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=> repeater_mode == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_REPEATER]))
    else $error("repeater mode not taken");

  aps_wr_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    wr_ctrl |=> auto_power_save == $past(reg_wdata[phy_vendor_regs_pkg::CTRL_APS]))
    else $error("auto power save not taken");

  soft_mdix_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    soft_reset && !wr_ctrl && state.strap_done |=> mdix_auto_disable == state.strap_an_off)
    else $error("software reset lost crossover strap value");

  ctrl_read_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    rd_ctrl |=> reg_rdata == $past(state.ctrl))
    else $error("control read data wrong");

  link_flag_rd_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    rd_irq && flags[phy_vendor_regs_pkg::EVT_LINK] |=>
      reg_rdata[phy_vendor_regs_pkg::IRQ_FLAG_LINK])
    else $error("link flag missing from read data");

  speed_flag_rd_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    rd_irq && flags[phy_vendor_regs_pkg::EVT_SPEED] |=>
      reg_rdata[phy_vendor_regs_pkg::IRQ_FLAG_SPEED])
    else $error("speed flag missing from read data");

  duplex_flag_rd_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    rd_irq && flags[phy_vendor_regs_pkg::EVT_DUPLX] |=>
      reg_rdata[phy_vendor_regs_pkg::IRQ_FLAG_DUPLX])
    else $error("duplex flag missing from read data");

  arb_flag_rd_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    rd_irq && flags[phy_vendor_regs_pkg::EVT_ARB] |=>
      reg_rdata[phy_vendor_regs_pkg::IRQ_FLAG_ARB])
    else $error("arbiter flag missing from read data");

  link_irq_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    !state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_ALL] &&
      !state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_LINK] &&
      flags[phy_vendor_regs_pkg::EVT_LINK] |-> irq_output)
    else $error("unmasked link flag gave no interrupt");

  speed_irq_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    !state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_ALL] &&
      !state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_SPEED] &&
      flags[phy_vendor_regs_pkg::EVT_SPEED] |-> irq_output)
    else $error("unmasked speed flag gave no interrupt");

  duplex_irq_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    !state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_ALL] &&
      !state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_DUPLX] &&
      flags[phy_vendor_regs_pkg::EVT_DUPLX] |-> irq_output)
    else $error("unmasked duplex flag gave no interrupt");

  arb_irq_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    !state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_ALL] &&
      state.irq_cfg[phy_vendor_regs_pkg::IRQ_ARB_EN] &&
      flags[phy_vendor_regs_pkg::EVT_ARB] |-> irq_output)
    else $error("enabled arbiter flag gave no interrupt");

  speed_mask_a: assert property (
    @(posedge mclk) disable iff (!rst_sync)
    state.irq_cfg[phy_vendor_regs_pkg::IRQ_MASK_SPEED] &&
      flags == (4'h1 << phy_vendor_regs_pkg::EVT_SPEED) |-> !irq_output)
    else $error("masked speed event raised interrupt");

endmodule // phy_vendor_ctrl_irq_regs

// >>> dv/mac_mgmt_model.sv
`timescale 1ns/1ps

module mac_mgmt_model (
  // clock
  input  wire logic        mclk,
  // register port toward the device
  output logic      [4:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    // stale data must not look valid once the write is taken
    reg_wdata <= ~d;
    // let the edge that takes the write settle before anyone looks at outputs
    #1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask
endmodule // mac_mgmt_model

// >>> dv/phy_vendor_ctrl_irq_regs_bench.sv
`timescale 1ns/1ps

module phy_vendor_ctrl_irq_regs_bench;
  logic        mclk         = 1'b0;
  logic        resetn       = 1'b0;
  logic        soft_reset   = 1'b0;
  logic        an_strap_off = 1'b0;
  logic [3:0]  ev           = 4'h0;
  logic [4:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [9:0]  ctl;
  logic        irq_output;
  logic        irq_output_oe;
  logic [15:0] rdv;
  int          err_total  = 0;
  int          num_checks = 0;
  int          i;
  logic [15:0] irq_w [0:9] = '{16'h0E00, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
                               16'h8080, 16'h8400, 16'h8200, 16'h8100, 16'h8800};
  logic [15:0] irq_r [0:9] = '{16'h0E04, 16'h8004, 16'h8002, 16'h8001, 16'h8040,
                               16'h80C0, 16'h8402, 16'h8201, 16'h8104, 16'h8804};
  int          irq_k [0:9] = '{2, 2, 1, 0, 3, 3, 1, 0, 2, 2};
  logic [9:0]  irq_x       = 10'b0111010000;

  always #25 mclk = ~mclk;

  mac_mgmt_model mac_mgmt_model_i (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  phy_vendor_ctrl_irq_regs phy_vendor_ctrl_irq_regs_i (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .soft_reset(soft_reset), .an_strap_off(an_strap_off),
    .speed_change(ev[1]), .duplex_change(ev[0]), .link_change(ev[2]),
    .arbiter_change(ev[3]), .debug_mode(ctl[9]), .mdix_auto_disable(ctl[8]),
    .heartbeat_en(ctl[7]), .jabber_en(ctl[6]), .far_end_fault_en(ctl[5]),
    .an_power_save_disable(ctl[4]), .dsp_reset_bypass(ctl[3]),
    .repeater_mode(ctl[2]), .auto_power_save(ctl[1]), .analog_power_down(ctl[0]),
    .irq_output(irq_output), .irq_output_oe(irq_output_oe)
  );

  function automatic logic [9:0] ctl_of(input logic [15:0] d);
    return {d[15], d[11], d[10], d[9], d[8], d[7], d[5], d[2], d[1], d[0]};
  endfunction

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_level(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic hw_reset(input logic strap);
    @(posedge mclk);
    resetn       <= 1'b0;
    an_strap_off <= strap;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    mac_mgmt_model_i.rd(a, rdv);
    check_word(rdv, exp);
  endtask

  task automatic pulse(input int k);
    @(posedge mclk);
    ev <= 4'h1 << k;
    @(posedge mclk);
    ev <= 4'h0;
    @(posedge mclk);
    #1;
  endtask

  // bounded at over twenty times the expected run length
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    $display("[FAIL] %0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
    results();
  end

  initial begin
    hw_reset(1'b0);
    rd_chk(5'h10, 16'h0000);
    rd_chk(5'h11, 16'h0E00);
    check_level({8'h00, irq_output_oe, irq_output}, 10'h000);
    // unmapped address reads zero
    rd_chk(5'h05, 16'h0000);
    for (i = 0; i < 16; i++) begin
      mac_mgmt_model_i.wr(5'h10, 16'h0001 << i);
      check_level(ctl, ctl_of(16'h0001 << i));
      rd_chk(5'h10, (16'h0001 << i) & 16'h8FA7);
    end
    mac_mgmt_model_i.wr(5'h10, 16'hFFFF);
    @(posedge mclk);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    rd_chk(5'h10, 16'h87A7);
    check_level(ctl, ctl_of(16'h87A7));
    hw_reset(1'b0);
    rd_chk(5'h10, 16'h0000);
    hw_reset(1'b1);
    rd_chk(5'h10, 16'h0800);
    check_level(ctl, ctl_of(16'h0800));
    // software wants automatic crossover back, so it clears the bit itself
    mac_mgmt_model_i.wr(5'h10, 16'h0000);
    rd_chk(5'h10, 16'h0000);
    for (i = 0; i < 10; i++) begin
      mac_mgmt_model_i.wr(5'h11, irq_w[i]);
      pulse(irq_k[i]);
      check_level({8'h00, irq_output_oe, irq_output}, {8'h00, irq_w[i][15], irq_x[9-i]});
      rd_chk(5'h11, irq_r[i]);
      check_level({8'h00, irq_output_oe, irq_output}, {8'h00, irq_w[i][15], 1'b0});
    end
    rd_chk(5'h11, 16'h8800);
    results();
  end
endmodule // phy_vendor_ctrl_irq_regs_bench
